// ==== logic/pap_top.sv ====
// Power amplifier protection: power readback and gain-off enables
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Readback shows the latest average power while within the limit and the protect flag is clear.
// - Power uses only the six top bits of each I and Q word.
// - Unexpected character threshold forces gain off when bit 7 is set.
// - Delay buffer error forces gain off when datapath bit 1 is set.
// - Lane FIFO error forces gain off when datapath bit 0 is set.
// - Lane 0 configuration mismatch forces gain off when link bit 7 is set.
// - Code group sync failure forces gain off when link bit 6 is set.
// - Frame sync failure forces gain off when link bit 5 is set.
// - Configuration checksum failure forces gain off when link bit 4 is set.
// - Initial lane alignment failure forces gain off when link bit 3 is set.
// - Lane deskew failure forces gain off when link bit 2 is set.
// - Disparity count over threshold forces gain off when link bit 1 set.
// - Not-in-table count over threshold forces gain off when link bit 0 set.
// - Average power is compared with a 13-bit limit in low and high fields.
// - Averaging runs only while the averaging enable bit 7 is set.
// - Window spans two to the nine plus N pairs, N clamped to ten.
module pap_top #(
  parameter int DATA_W = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pap_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pap_pkg::REG_W-1:0] reg_wdata,
  output logic [pap_pkg::REG_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] q_data,
  input wire logic lane_fifo_error,
  input wire logic delay_buffer_error,
  input wire logic unexpected_char_error,
  input wire logic config_mismatch,
  input wire logic code_group_sync_fail,
  input wire logic frame_sync_fail,
  input wire logic checksum_fail,
  input wire logic lane_align_fail,
  input wire logic deskew_fail,
  input wire logic disparity_errors,
  input wire logic not_in_table_errors,
  output logic gain_off_request,
  output logic power_protect_flag
);
  import pap_pkg::*;

  logic [RESET_SYNC_STAGES-1:0] rst_pipe;
  logic rst_n;
  logic [POWER_W-1:0] power_limit;
  logic average_power_enable;
  logic [AVG_SEL_W-1:0] averaging_window_select;
  logic [REG_W-1:0] gain_off_enable_datapath;
  logic [REG_W-1:0] gain_off_enable_link;
  logic [POWER_W-1:0] average_power_readback;
  logic [POWER_W-1:0] avg_value;
  logic avg_valid;
  logic over_limit;
  logic [REG_W-1:0] datapath_err;
  logic [REG_W-1:0] link_err;
  logic any_source;
  logic [REG_W-1:0] next_rdata;
  logic [ADDR_W-1:0] rd_addr_q;

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= '0;
    end else begin
      rst_pipe <= {rst_pipe[RESET_SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[RESET_SYNC_STAGES-1];

  pap_power_avg #(
    .DATA_W(DATA_W)
  ) u_avg (
    .clk(mclk),
    .rst_n(rst_n),
    .enable(average_power_enable),
    .window_sel(averaging_window_select),
    .sample_valid(sample_valid),
    .i_data(i_data),
    .q_data(q_data),
    .avg_value(avg_value),
    .avg_valid(avg_valid)
  );

  // Register writes; reserved enable bits are not stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_limit <= RESET_POWER;
      average_power_enable <= 1'b0;
      averaging_window_select <= '0;
      gain_off_enable_datapath <= RESET_REG;
      gain_off_enable_link <= RESET_REG;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_LIMIT_LOW: power_limit[REG_W-1:0] <= reg_wdata;
        OFS_LIMIT_HIGH: power_limit[POWER_W-1:REG_W] <=
          reg_wdata[HIGH_FIELD_W-1:0];
        OFS_AVG_CTRL: begin
          average_power_enable <= reg_wdata[BIT_AVG_ENABLE];
          averaging_window_select <= reg_wdata[AVG_SEL_W-1:0];
        end
        OFS_GAIN_OFF_DATAPATH: gain_off_enable_datapath <=
          reg_wdata & DATAPATH_EN_MASK;
        OFS_GAIN_OFF_LINK: gain_off_enable_link <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  assign over_limit = avg_value > power_limit;

  // Readback freezes at the last value that stayed within the limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      average_power_readback <= RESET_POWER;
    end else if (avg_valid && !over_limit && !power_protect_flag) begin
      average_power_readback <= avg_value;
    end
  end

  // Flag holds until averaging is switched off; no new result can then set it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_protect_flag <= 1'b0;
    end else if (avg_valid && over_limit) begin
      power_protect_flag <= 1'b1;
    end else if (!average_power_enable) begin
      power_protect_flag <= 1'b0;
    end
  end

  assign datapath_err = {unexpected_char_error, 5'h00,
                         delay_buffer_error, lane_fifo_error};
  assign link_err = {config_mismatch, code_group_sync_fail, frame_sync_fail,
                     checksum_fail, lane_align_fail, deskew_fail,
                     disparity_errors, not_in_table_errors};
  // Sources are levels from the receiver; the request follows them
  assign any_source = |(gain_off_enable_datapath & datapath_err) |
                      |(gain_off_enable_link & link_err);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gain_off_request <= 1'b0;
    end else begin
      gain_off_request <= any_source;
    end
  end

  // Read data; unmapped addresses answer zero
  always_comb begin
    next_rdata = RESET_REG;
    unique case (reg_addr)
      OFS_LIMIT_LOW: next_rdata = power_limit[REG_W-1:0];
      OFS_LIMIT_HIGH: next_rdata = {3'h0, power_limit[POWER_W-1:REG_W]};
      OFS_AVG_CTRL: next_rdata = {average_power_enable, 3'h0,
                                  averaging_window_select};
      OFS_POWER_LOW: next_rdata = average_power_readback[REG_W-1:0];
      OFS_POWER_HIGH: next_rdata =
        {3'h0, average_power_readback[POWER_W-1:REG_W]};
      OFS_GAIN_OFF_DATAPATH: next_rdata = gain_off_enable_datapath;
      OFS_GAIN_OFF_LINK: next_rdata = gain_off_enable_link;
      default: next_rdata = RESET_REG;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RESET_REG;
      reg_rvalid <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
        rd_addr_q <= reg_addr;
      end
    end
  end

  a_readback_tracks: assert property (@(posedge mclk)
    disable iff (!rst_n) avg_valid && !over_limit && !power_protect_flag
    |=> average_power_readback == $past(avg_value))
    else $error("readback not updated");
  a_readback_frozen: assert property (@(posedge mclk)
    disable iff (!rst_n) power_protect_flag
    |=> $stable(average_power_readback))
    else $error("readback moved past limit");
  a_protect_sets: assert property (@(posedge mclk)
    disable iff (!rst_n) avg_valid && over_limit
    |=> power_protect_flag) else $error("protect flag not set");
  a_protect_cause: assert property (@(posedge mclk)
    disable iff (!rst_n) $rose(power_protect_flag)
    |-> $past(avg_value) > $past(power_limit))
    else $error("protect flag without cause");
  a_fifo_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_datapath[BIT_LANE_FIFO] &&
    lane_fifo_error |=> gain_off_request) else $error("fifo error missed");
  a_buffer_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_datapath[BIT_DELAY_BUFFER] &&
    delay_buffer_error |=> gain_off_request)
    else $error("buffer error missed");
  a_char_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_datapath[BIT_UNEXPECTED_CHAR] &&
    unexpected_char_error |=> gain_off_request)
    else $error("char error missed");
  a_mismatch_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_link[BIT_CONFIG_MISMATCH] &&
    config_mismatch |=> gain_off_request) else $error("mismatch missed");
  a_sync_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_link[BIT_CODE_GROUP_SYNC] &&
    code_group_sync_fail |=> gain_off_request)
    else $error("sync failure missed");
  a_link_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) |(gain_off_enable_link & link_err)
    |=> gain_off_request) else $error("link error missed");
  a_nit_gain_off: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_link[BIT_NOT_IN_TABLE] &&
    not_in_table_errors |=> gain_off_request)
    else $error("table error missed");
  a_masked_quiet: assert property (@(posedge mclk)
    disable iff (!rst_n) gain_off_enable_datapath == 8'h00 &&
    gain_off_enable_link == 8'h00 |=> !gain_off_request)
    else $error("request while all disabled");
  a_request_cause: assert property (@(posedge mclk)
    disable iff (!rst_n) !any_source |=> !gain_off_request)
    else $error("request without source");
  a_reserved_zero: assert property (@(posedge mclk)
    disable iff (!rst_n) reg_rvalid && rd_addr_q == OFS_POWER_HIGH
    |-> reg_rdata[7:5] == 3'h0) else $error("reserved bits set");
  c_protect_trip: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(power_protect_flag));
  c_gain_off: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(gain_off_request));
  c_avg_result: cover property (@(posedge mclk) disable iff (!rst_n)
    avg_valid && !over_limit);
  c_reg_read: cover property (@(posedge mclk) disable iff (!rst_n)
    reg_rvalid && rd_addr_q == OFS_POWER_LOW);
endmodule : pap_top
`default_nettype wire

// ==== include/pap_pkg.sv ====
// Constants shared by the power amplifier protection block
package pap_pkg;
  localparam int ADDR_W = 12;
  localparam int REG_W = 8;
  localparam logic [11:0] OFS_LIMIT_LOW = 12'h060;
  localparam logic [11:0] OFS_LIMIT_HIGH = 12'h061;
  localparam logic [11:0] OFS_AVG_CTRL = 12'h062;
  localparam logic [11:0] OFS_POWER_LOW = 12'h063;
  localparam logic [11:0] OFS_POWER_HIGH = 12'h064;
  localparam logic [11:0] OFS_GAIN_OFF_DATAPATH = 12'h065;
  localparam logic [11:0] OFS_GAIN_OFF_LINK = 12'h066;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [12:0] RESET_POWER = 13'h0000;
  localparam int POWER_W = 13;
  localparam int HIGH_FIELD_W = 5;
  localparam int BIT_AVG_ENABLE = 7;
  localparam int AVG_SEL_W = 4;
  localparam logic [3:0] AVG_SEL_MAX = 4'ha;
  localparam int AVG_BASE_LOG2 = 9;
  localparam int MSB_BITS = 6;
  localparam int SQ_W = 11;
  localparam int PAIR_W = 12;
  localparam logic [11:0] PAIR_MAX = 12'h800;
  localparam int CNT_W = 20;
  localparam int ACC_W = 32;
  localparam int BIT_UNEXPECTED_CHAR = 7;
  localparam int BIT_DELAY_BUFFER = 1;
  localparam int BIT_LANE_FIFO = 0;
  localparam logic [7:0] DATAPATH_EN_MASK = 8'h83;
  localparam int BIT_CONFIG_MISMATCH = 7;
  localparam int BIT_CODE_GROUP_SYNC = 6;
  localparam int BIT_FRAME_SYNC = 5;
  localparam int BIT_CHECKSUM = 4;
  localparam int BIT_LANE_ALIGN = 3;
  localparam int BIT_DESKEW = 2;
  localparam int BIT_DISPARITY = 1;
  localparam int BIT_NOT_IN_TABLE = 0;
  localparam int RESET_SYNC_STAGES = 2;
endpackage : pap_pkg

// ==== logic/pap_power_avg.sv ====
// Windowed average of I squared plus Q squared
`timescale 1ns/1ps
`default_nettype none
module pap_power_avg #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [pap_pkg::AVG_SEL_W-1:0] window_sel,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [DATA_W-1:0] q_data,
  output logic [pap_pkg::POWER_W-1:0] avg_value,
  output logic avg_valid
);
  import pap_pkg::*;

  function automatic logic [SQ_W-1:0] square_msbs(input logic [DATA_W-1:0] d);
    logic signed [MSB_BITS-1:0] v;
    logic signed [2*MSB_BITS-1:0] p;
    v = d[DATA_W-1 -: MSB_BITS];
    p = v * v;
    return p[SQ_W-1:0];
  endfunction : square_msbs

  logic [AVG_SEL_W-1:0] sel_clamped;
  int shift;
  logic [CNT_W-1:0] window_last;
  logic [PAIR_W-1:0] pair_power;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [CNT_W-1:0] sample_cnt;

  // Settings above the top of the range act as the top
  assign sel_clamped = (window_sel > AVG_SEL_MAX) ? AVG_SEL_MAX : window_sel;
  assign shift = AVG_BASE_LOG2 + int'(sel_clamped);
  assign window_last = CNT_W'((64'd1 << shift) - 64'd1);
  // Squares see only the top bits of each word
  assign pair_power = {1'b0, square_msbs(i_data)} +
                      {1'b0, square_msbs(q_data)};
  assign next_acc = acc + ACC_W'(pair_power);

  // Block average: one result per full window, cheaper than a sliding sum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      sample_cnt <= '0;
      avg_value <= RESET_POWER;
      avg_valid <= 1'b0;
    end else if (!enable) begin
      acc <= '0;
      sample_cnt <= '0;
      avg_valid <= 1'b0;
    end else begin
      avg_valid <= 1'b0;
      if (sample_valid) begin
        if (sample_cnt == window_last) begin
          avg_value <= POWER_W'(next_acc >> shift);
          acc <= '0;
          sample_cnt <= '0;
          avg_valid <= 1'b1;
        end else begin
          acc <= next_acc;
          sample_cnt <= sample_cnt + CNT_W'(1);
        end
      end
    end
  end

  a_pair_range: assert property (@(posedge clk)
    disable iff (!rst_n) pair_power <= PAIR_MAX)
    else $error("pair power too wide");
  a_idle_no_result: assert property (@(posedge clk)
    disable iff (!rst_n) !enable |=> !avg_valid)
    else $error("result while disabled");
  a_window_end: assert property (@(posedge clk)
    disable iff (!rst_n) $rose(avg_valid) |->
    $past(sample_cnt) == $past(window_last) && $past(sample_valid))
    else $error("window length wrong");
endmodule : pap_power_avg
`default_nettype wire

// ==== tb/pap_link_model.sv ====
// Receiver-side model: I/Q sample source and link error levels
`timescale 1ns/1ps
`default_nettype none
module pap_link_model (
  input wire logic mclk,
  input wire logic run,
  input wire logic [5:0] i6,
  input wire logic [5:0] q6,
  input wire logic [10:0] err_req,
  output logic sample_valid,
  output logic [15:0] i_data,
  output logic [15:0] q_data,
  output logic [10:0] err_lines
);
  logic [15:0] idle_pat = 16'h5a5a;
  // Idle data keeps toggling so a stale word never looks valid
  always @(negedge mclk) begin
    idle_pat <= ~idle_pat;
  end
  // Low ten bits set to show that only the top six count
  assign sample_valid = run;
  assign i_data = run ? {i6, 10'h3ff} : idle_pat;
  assign q_data = run ? {q6, 10'h3ff} : ~idle_pat;
  assign err_lines = err_req;
endmodule : pap_link_model
`default_nettype wire

// ==== tb/power_amp_protection_tb.sv ====
// Self-checking bench for the power amplifier protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module power_amp_protection_tb;
  import pap_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0] reg_wdata = '0;
  logic [REG_W-1:0] reg_rdata;
  logic reg_rvalid, sample_valid, gain_off_request, power_protect_flag;
  logic [15:0] i_data, q_data;
  logic run = 1'b0;
  logic [5:0] i6 = '0;
  logic [5:0] q6 = '0;
  logic [10:0] err_req = '0;
  logic [10:0] err_lines;
  logic [7:0] b;
  logic link;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  pap_link_model model_u (.mclk(mclk), .run(run), .i6(i6), .q6(q6),
    .err_req(err_req), .sample_valid(sample_valid), .i_data(i_data),
    .q_data(q_data), .err_lines(err_lines));

  pap_top #(.DATA_W(16)) dut_u (.mclk(mclk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sample_valid(sample_valid), .i_data(i_data), .q_data(q_data),
    .lane_fifo_error(err_lines[8]), .delay_buffer_error(err_lines[9]),
    .unexpected_char_error(err_lines[10]), .config_mismatch(err_lines[7]),
    .code_group_sync_fail(err_lines[6]), .frame_sync_fail(err_lines[5]),
    .checksum_fail(err_lines[4]), .lane_align_fail(err_lines[3]),
    .deskew_fail(err_lines[2]), .disparity_errors(err_lines[1]),
    .not_in_table_errors(err_lines[0]), .gain_off_request(gain_off_request),
    .power_protect_flag(power_protect_flag));

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd

  // One full window at the shortest setting
  task automatic window(input logic [5:0] i, input logic [5:0] q);
    @(negedge mclk);
    run = 1'b1;
    i6 = i;
    q6 = q;
    repeat (512) @(negedge mclk);
    run = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : window

  task automatic results;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Whole run is about 3000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    for (int a = 'h60; a <= 'h66; a++) begin
      rd(12'(a), 8'h00);
    end
    rd(12'h0ff, 8'h00);
    wr(OFS_GAIN_OFF_DATAPATH, 8'hff);
    rd(OFS_GAIN_OFF_DATAPATH, 8'h83);
    wr(OFS_GAIN_OFF_LINK, 8'hff);
    rd(OFS_GAIN_OFF_LINK, 8'hff);
    wr(OFS_POWER_LOW, 8'hff);
    rd(OFS_POWER_LOW, 8'h00);
    wr(OFS_LIMIT_HIGH, 8'hff);
    rd(OFS_LIMIT_HIGH, 8'h1f);
    // Each source alone, then every enable but its own
    for (int k = 0; k < 11; k++) begin
      link = (k < 8);
      b = 8'h01 << (link ? k : (k == 8 ? 0 : (k == 9 ? 1 : 7)));
      wr(OFS_GAIN_OFF_DATAPATH, link ? 8'h00 : b);
      wr(OFS_GAIN_OFF_LINK, link ? b : 8'h00);
      @(negedge mclk);
      err_req = 11'h001 << k;
      @(negedge mclk);
      `CHK(gain_off_request, 1'b1)
      err_req = '0;
      @(negedge mclk);
      `CHK(gain_off_request, 1'b0)
      wr(OFS_GAIN_OFF_DATAPATH, link ? 8'h83 : (8'h83 & ~b));
      wr(OFS_GAIN_OFF_LINK, link ? ~b : 8'hff);
      @(negedge mclk);
      err_req = 11'h001 << k;
      @(negedge mclk);
      `CHK(gain_off_request, 1'b0)
      err_req = '0;
    end
    // Samples while averaging is off leave the readback alone
    window(6'h20, 6'h20);
    rd(OFS_POWER_LOW, 8'h00);
    rd(OFS_POWER_HIGH, 8'h00);
    // Limit equal to the average: no flag, as the compare is strict
    wr(OFS_LIMIT_LOW, 8'h00);
    wr(OFS_LIMIT_HIGH, 8'h08);
    wr(OFS_AVG_CTRL, 8'h80);
    window(6'h20, 6'h20);
    rd(OFS_POWER_LOW, 8'h00);
    rd(OFS_POWER_HIGH, 8'h08);
    `CHK(power_protect_flag, 1'b0)
    // 25 + 9 = 34 is over 33: flag rises, readback stays frozen
    wr(OFS_LIMIT_LOW, 8'h21);
    wr(OFS_LIMIT_HIGH, 8'h00);
    window(6'h05, 6'h3d);
    `CHK(power_protect_flag, 1'b1)
    rd(OFS_POWER_LOW, 8'h00);
    rd(OFS_POWER_HIGH, 8'h08);
    wr(OFS_AVG_CTRL, 8'h00);
    @(negedge mclk);
    `CHK(power_protect_flag, 1'b0)
    // N = 1: half a window gives no result, the second half does
    wr(OFS_LIMIT_LOW, 8'h22);
    wr(OFS_AVG_CTRL, 8'hf1);
    rd(OFS_AVG_CTRL, 8'h81);
    window(6'h05, 6'h3d);
    rd(OFS_POWER_LOW, 8'h00);
    window(6'h05, 6'h3d);
    rd(OFS_POWER_LOW, 8'h22);
    rd(OFS_POWER_HIGH, 8'h00);
    `CHK(power_protect_flag, 1'b0)
    results();
  end
endmodule : power_amp_protection_tb
`undef CHK
`default_nettype wire
